// ===== pkg/ccd_regs.svh
// constants for the can command blocks
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

// opcodes and lengths in words
`define CCD_OP_RATE       16'h0047
`define CCD_OP_LOCAL      16'h0048
`define CCD_OP_CONNECT    16'h0049
`define CCD_LEN_RATE      5'h02
`define CCD_LEN_LOCAL     5'h06
`define CCD_LEN_CONNECT   5'h12

// rate parameter codes
`define CCD_RATE_1M       4'h0
`define CCD_RATE_MAXCODE  16'h0008
`define CCD_RATE_SWITCH   16'h00ff

// local access modes
`define CCD_MODE_RD_REG   16'h0000
`define CCD_MODE_WR_REG   16'h0001
`define CCD_MODE_WR_CONST 16'h0002

// dictionary objects
`define CCD_IDX_CLIENT1   16'h1280
`define CCD_IDX_SWITCH    16'h200a
`define CCD_SUB_SWITCH    8'h00
`define CCD_SW_LSB        4
`define CCD_COB_RX_BASE   32'h0000_0600
`define CCD_COB_TX_BASE   32'h0000_0580

// host register offsets
`define CCD_OFF_CMD       8'h00
`define CCD_OFF_P0        8'h04
`define CCD_OFF_P1        8'h08
`define CCD_OFF_P2        8'h0c
`define CCD_OFF_STATUS    8'h10
`define CCD_OFF_IRQ_STAT  8'h14
`define CCD_OFF_IRQ_MASK  8'h18
`define CCD_OFF_ERR_CLR   8'h1c

// host field positions and limits
`define CCD_IRQ_DONE      0
`define CCD_IRQ_ERR       1
`define CCD_ID_MAX        16'h007f
`define CCD_CLIENT_MAX    32'h0000_0002

`endif

// ===== pkg/ccd_pkg.sv
// types shared by the can command blocks
package ccd_pkg;

  typedef enum logic [7:0] {
    DEV_COLLECT  = 8'b0000_0001,
    DEV_DECODE   = 8'b0000_0010,
    DEV_REGRD_LO = 8'b0000_0100,
    DEV_REGRD_HI = 8'b0000_1000,
    DEV_DICT     = 8'b0001_0000,
    DEV_REGWR_HI = 8'b0010_0000,
    DEV_ACK      = 8'b0100_0000,
    DEV_HALT     = 8'b1000_0000
  } ccd_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b001,
    HST_SEND = 3'b010,
    HST_WAIT = 3'b100
  } ccd_hst_state_t;

  typedef enum logic [1:0] {
    KIND_RATE    = 2'h0,
    KIND_CONNECT = 2'h1,
    KIND_LOCAL   = 2'h2
  } ccd_kind_t;

endpackage

// ===== pkg/ccd_link_if.sv
// serial command path from host to device
`timescale 1ns/1ps
`default_nettype none
interface ccd_link_if;
  logic [15:0] cmd_word;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        ack;
  logic        err;
  logic        err_clr;

  modport dev (
    input  cmd_word,
    input  cmd_valid,
    output cmd_ready,
    output ack,
    output err,
    input  err_clr
  );

  modport host (
    output cmd_word,
    output cmd_valid,
    input  cmd_ready,
    input  ack,
    input  err,
    output err_clr
  );
endinterface
`default_nettype wire

// ===== src/ccd_device.sv
// device end: decodes the can command set
// How it works
// - 1 Mb/s after reset
// - codes 0..8 map to nine rates
// - code 5 accepted, selects 100 kb/s
// - 255 takes rate from switch
// - switch shown in object bits 4-7
// - rate command opcode 71, two words
// - connect binds client to node's server
// - connect writes object 1280h or 1281h
// - connect: 18 words, three local writes
// - issuer gives node 1..127 and client
// - read copies object; write reg/const
// - mode 0 read, 1 reg write, 2 const
// - modes 0,1 register number; 2 constant
// - objects chosen by index and sub-index
// - invalid access: error and halt
// - time-of-day object spans two registers
// - local access opcode 72, six words
// - master configures objects before can use
`include "ccd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccd_device (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // command link
  ccd_link_if.dev          link,
  // can rate and rotary switch
  input  wire logic [3:0]  rot_sw_i,
  output logic      [3:0]  can_rate_o,
  // dictionary store
  output logic             dict_req_o,
  output logic             dict_we_o,
  output logic      [15:0] dict_index_o,
  output logic      [7:0]  dict_sub_o,
  output logic      [31:0] dict_wdata_o,
  output logic      [31:0] dict_wdata_hi_o,
  input  wire logic        dict_ack_i,
  input  wire logic        dict_err_i,
  input  wire logic        dict_tod_i,
  input  wire logic [31:0] dict_rdata_i,
  input  wire logic [31:0] dict_rdata_hi_i,
  // user registers
  output logic             reg_we_o,
  output logic      [15:0] reg_addr_o,
  output logic      [31:0] reg_wdata_o,
  input  wire logic [31:0] reg_rdata_i
);

  ccd_pkg::ccd_dev_state_t state;
  logic [15:0] w [0:5];
  logic [4:0]  cnt;
  logic [4:0]  len;
  logic [1:0]  step;
  logic [3:0]  sw_meta;
  logic [3:0]  sw_sync;
  logic        sw_mode;
  logic [3:0]  rate_code;
  logic        ready;
  logic        ack;
  logic        err;
  logic [31:0] hi_val;
  logic [31:0] next_rdata;
  logic        take;

  assign link.cmd_ready = ready;
  assign link.ack       = ack;
  assign link.err       = err;
  assign take           = link.cmd_valid & ready;

  ////////////////////////////////////////////////////////////////////////
  // switch sync and rate output

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sw_meta <= 4'h0;
      sw_sync <= 4'h0;
    end else begin
      sw_meta <= rot_sw_i;
      sw_sync <= sw_meta;
    end
  end

  // live switch: no reprogramming needed
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      can_rate_o <= `CCD_RATE_1M;
    end else if (sw_mode) begin
      if ({12'h000, sw_sync} <= `CCD_RATE_MAXCODE) begin
        can_rate_o <= sw_sync;
      end else begin
        can_rate_o <= `CCD_RATE_1M;
      end
    end else begin
      can_rate_o <= rate_code;
    end
  end

  // switch merged into its object
  always_comb begin
    next_rdata = dict_rdata_i;
    if (dict_index_o == `CCD_IDX_SWITCH && dict_sub_o == `CCD_SUB_SWITCH) begin
      next_rdata[`CCD_SW_LSB +: 4] = sw_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command word collection

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt <= 5'h00;
      len <= 5'h00;
      for (int i = 0; i < 6; i++) begin
        w[i] <= 16'h0000;
      end
    end else if (take) begin
      cnt <= (cnt == len - 5'h01 && cnt != 5'h00) ? 5'h00 : cnt + 5'h01;
      if (cnt < 5'h06) begin
        w[cnt[2:0]] <= link.cmd_word;
      end
      if (cnt == 5'h00) begin
        case (link.cmd_word)
          `CCD_OP_RATE:    len <= `CCD_LEN_RATE;
          `CCD_OP_LOCAL:   len <= `CCD_LEN_LOCAL;
          `CCD_OP_CONNECT: len <= `CCD_LEN_CONNECT;
          default:         len <= 5'h00;
        endcase
      end
    end else if (state == ccd_pkg::DEV_HALT) begin
      cnt <= 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execution sequencer

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state           <= ccd_pkg::DEV_COLLECT;
      ready           <= 1'b0;
      ack             <= 1'b0;
      err             <= 1'b0;
      step            <= 2'h0;
      sw_mode         <= 1'b0;
      rate_code       <= `CCD_RATE_1M;
      hi_val          <= 32'h0000_0000;
      dict_req_o      <= 1'b0;
      dict_we_o       <= 1'b0;
      dict_index_o    <= 16'h0000;
      dict_sub_o      <= 8'h00;
      dict_wdata_o    <= 32'h0000_0000;
      dict_wdata_hi_o <= 32'h0000_0000;
      reg_we_o        <= 1'b0;
      reg_addr_o      <= 16'h0000;
      reg_wdata_o     <= 32'h0000_0000;
    end else begin
      ack      <= 1'b0;
      reg_we_o <= 1'b0;
      case (state)
        ccd_pkg::DEV_COLLECT: begin
          ready <= 1'b1;
          if (take && cnt == 5'h00 &&
              link.cmd_word != `CCD_OP_RATE &&
              link.cmd_word != `CCD_OP_LOCAL &&
              link.cmd_word != `CCD_OP_CONNECT) begin
            ready <= 1'b0;
            err   <= 1'b1;
            state <= ccd_pkg::DEV_HALT;
          end else if (take && cnt != 5'h00 && cnt == len - 5'h01) begin
            ready <= 1'b0;
            step  <= 2'h0;
            state <= ccd_pkg::DEV_DECODE;
          end
        end
        ccd_pkg::DEV_DECODE: begin
          if (w[0] == `CCD_OP_RATE) begin
            if (w[1] == `CCD_RATE_SWITCH) begin
              sw_mode <= 1'b1;
              state   <= ccd_pkg::DEV_ACK;
            end else if (w[1] <= `CCD_RATE_MAXCODE) begin
              sw_mode   <= 1'b0;
              rate_code <= w[1][3:0];
              state     <= ccd_pkg::DEV_ACK;
            end else begin
              err   <= 1'b1;
              state <= ccd_pkg::DEV_HALT;
            end
          end else if (w[0] == `CCD_OP_CONNECT) begin
            // padding after client
            if (w[2] == 16'h0001 || w[2] == 16'h0002) begin
              dict_req_o   <= 1'b1;
              dict_we_o    <= 1'b1;
              dict_index_o <= `CCD_IDX_CLIENT1 + w[2] - 16'h0001;
              dict_sub_o   <= {6'h00, step + 2'h1};
              case (step)
                2'h0:    dict_wdata_o <= `CCD_COB_RX_BASE + {16'h0000, w[1]};
                2'h1:    dict_wdata_o <= `CCD_COB_TX_BASE + {16'h0000, w[1]};
                default: dict_wdata_o <= {16'h0000, w[1]};
              endcase
              dict_wdata_hi_o <= 32'h0000_0000;
              state           <= ccd_pkg::DEV_DICT;
            end else begin
              err   <= 1'b1;
              state <= ccd_pkg::DEV_HALT;
            end
          end else begin
            dict_index_o <= w[4];
            dict_sub_o   <= w[5][7:0];
            reg_addr_o   <= w[3];
            case (w[1])
              `CCD_MODE_RD_REG: begin
                dict_req_o <= 1'b1;
                dict_we_o  <= 1'b0;
                state      <= ccd_pkg::DEV_DICT;
              end
              `CCD_MODE_WR_REG: begin
                state <= ccd_pkg::DEV_REGRD_LO;
              end
              `CCD_MODE_WR_CONST: begin
                dict_req_o      <= 1'b1;
                dict_we_o       <= 1'b1;
                dict_wdata_o    <= {w[2], w[3]};
                dict_wdata_hi_o <= 32'h0000_0000;
                state           <= ccd_pkg::DEV_DICT;
              end
              default: begin
                err   <= 1'b1;
                state <= ccd_pkg::DEV_HALT;
              end
            endcase
          end
        end
        ccd_pkg::DEV_REGRD_LO: begin
          // both read; upper kept only for tod
          dict_wdata_o <= reg_rdata_i;
          reg_addr_o   <= reg_addr_o + 16'h0001;
          state        <= ccd_pkg::DEV_REGRD_HI;
        end
        ccd_pkg::DEV_REGRD_HI: begin
          dict_wdata_hi_o <= reg_rdata_i;
          dict_req_o      <= 1'b1;
          dict_we_o       <= 1'b1;
          state           <= ccd_pkg::DEV_DICT;
        end
        ccd_pkg::DEV_DICT: begin
          if (dict_ack_i) begin
            dict_req_o <= 1'b0;
            if (dict_err_i) begin
              err   <= 1'b1;
              state <= ccd_pkg::DEV_HALT;
            end else if (w[0] == `CCD_OP_CONNECT) begin
              step  <= step + 2'h1;
              state <= (step == 2'h2) ? ccd_pkg::DEV_ACK
                                      : ccd_pkg::DEV_DECODE;
            end else if (!dict_we_o) begin
              reg_we_o    <= 1'b1;
              reg_wdata_o <= next_rdata;
              hi_val      <= dict_rdata_hi_i;
              state       <= dict_tod_i ? ccd_pkg::DEV_REGWR_HI
                                        : ccd_pkg::DEV_ACK;
            end else begin
              state <= ccd_pkg::DEV_ACK;
            end
          end
        end
        ccd_pkg::DEV_REGWR_HI: begin
          reg_we_o    <= 1'b1;
          reg_addr_o  <= reg_addr_o + 16'h0001;
          reg_wdata_o <= hi_val;
          state       <= ccd_pkg::DEV_ACK;
        end
        ccd_pkg::DEV_ACK: begin
          ack   <= 1'b1;
          ready <= 1'b1;
          state <= ccd_pkg::DEV_COLLECT;
        end
        ccd_pkg::DEV_HALT: begin
          ready <= 1'b0;
          if (link.err_clr) begin
            err   <= 1'b0;
            ready <= 1'b1;
            state <= ccd_pkg::DEV_COLLECT;
          end
        end
        default: begin
          state <= ccd_pkg::DEV_COLLECT;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== src/ccd_host.sv
// host end: axi4-lite registers driving the link
`include "ccd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccd_host (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic      [1:0]  s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic      [31:0] s_rdata_o,
  output logic      [1:0]  s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  // interrupt
  output logic             irq_o,
  // command link
  ccd_link_if.host         link
);

  ccd_pkg::ccd_hst_state_t state;
  ccd_pkg::ccd_kind_t      kind;
  logic [31:0] p0;
  logic [31:0] p1;
  logic [31:0] p2;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic [4:0]  idx;
  logic [4:0]  len;
  logic [15:0] word;
  logic        valid;
  logic        clr;
  logic        wr_go;
  logic        start;
  logic        set_done;
  logic        set_err;
  logic [31:0] next_rdata;
  logic        rd_ok;

  assign link.cmd_word  = word;
  assign link.cmd_valid = valid;
  assign link.err_clr   = clr;
  assign wr_go = s_awvalid_i & s_wvalid_i & ~s_bvalid_o;
  assign start = wr_go & (s_awaddr_i == `CCD_OFF_CMD) &
                 (state == ccd_pkg::HST_IDLE) & s_wstrb_i[0];

  function automatic logic [15:0] word_at(input logic [4:0] i);
    word_at = 16'h0000;
    case (kind)
      ccd_pkg::KIND_RATE:
        word_at = (i == 5'h00) ? `CCD_OP_RATE : p0[15:0];
      ccd_pkg::KIND_CONNECT: begin
        if (i == 5'h00) word_at = `CCD_OP_CONNECT;
        else if (i == 5'h01) word_at = p0[15:0];
        else if (i == 5'h02) word_at = p1[15:0];
      end
      default: begin
        case (i)
          5'h00:   word_at = `CCD_OP_LOCAL;
          5'h01:   word_at = p0[15:0];
          5'h02:   word_at = p1[31:16];
          5'h03:   word_at = p1[15:0];
          5'h04:   word_at = p2[15:0];
          default: word_at = {8'h00, p2[23:16]};
        endcase
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write side; aw and w taken together

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_awready_o <= 1'b0;
      s_wready_o  <= 1'b0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= 2'b00;
      p0          <= 32'h0000_0000;
      p1          <= 32'h0000_0000;
      p2          <= 32'h0000_0000;
      irq_mask    <= 2'b00;
    end else begin
      s_awready_o <= wr_go;
      s_wready_o  <= wr_go;
      if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
      if (wr_go) begin
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= 2'b00;
        case (s_awaddr_i)
          `CCD_OFF_P0:       p0 <= s_wdata_i;
          `CCD_OFF_P1:       p1 <= s_wdata_i;
          `CCD_OFF_P2:       p2 <= s_wdata_i;
          `CCD_OFF_IRQ_MASK: irq_mask <= s_wdata_i[1:0];
          `CCD_OFF_CMD, `CCD_OFF_IRQ_STAT, `CCD_OFF_ERR_CLR: ;
          default:           s_bresp_o <= 2'b10;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read side

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_ok      = 1'b1;
    case (s_araddr_i)
      `CCD_OFF_CMD:      next_rdata = {30'h0, kind};
      `CCD_OFF_P0:       next_rdata = p0;
      `CCD_OFF_P1:       next_rdata = p1;
      `CCD_OFF_P2:       next_rdata = p2;
      `CCD_OFF_STATUS:   next_rdata = {30'h0, link.err,
                                       state != ccd_pkg::HST_IDLE};
      `CCD_OFF_IRQ_STAT: next_rdata = {30'h0, irq_stat};
      `CCD_OFF_IRQ_MASK: next_rdata = {30'h0, irq_mask};
      `CCD_OFF_ERR_CLR:  next_rdata = 32'h0000_0000;
      default:           rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h0000_0000;
      s_rresp_o   <= 2'b00;
    end else begin
      s_arready_o <= s_arvalid_i & ~s_rvalid_o & ~s_arready_o;
      if (s_rvalid_o && s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
      if (s_arvalid_i && !s_rvalid_o && !s_arready_o) begin
        s_rvalid_o <= 1'b1;
        s_rdata_o  <= next_rdata;
        s_rresp_o  <= rd_ok ? 2'b00 : 2'b10;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // irq status: set wins over w1c

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_stat <= 2'b00;
      irq_o    <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == `CCD_IRQ_DONE && set_done) ||
            (b == `CCD_IRQ_ERR && set_err)) begin
          irq_stat[b] <= 1'b1;
        end else if (wr_go && s_awaddr_i == `CCD_OFF_IRQ_STAT &&
                     s_wdata_i[b]) begin
          irq_stat[b] <= 1'b0;
        end
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command sequencer

  always_comb begin
    set_done = (state == ccd_pkg::HST_WAIT) & link.ack;
    set_err  = ((state == ccd_pkg::HST_WAIT) & link.err & ~link.ack) |
               (start & (s_wdata_i[1:0] == ccd_pkg::KIND_CONNECT) &
                (p0[15:0] == 16'h0000 || p0[15:0] > `CCD_ID_MAX ||
                 p1 == 32'h0000_0000 || p1 > `CCD_CLIENT_MAX));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= ccd_pkg::HST_IDLE;
      kind  <= ccd_pkg::KIND_RATE;
      idx   <= 5'h00;
      len   <= 5'h00;
      word  <= 16'h0000;
      valid <= 1'b0;
      clr   <= 1'b0;
    end else begin
      clr <= wr_go & (s_awaddr_i == `CCD_OFF_ERR_CLR) & s_wdata_i[0];
      case (state)
        ccd_pkg::HST_IDLE: begin
          if (start && !set_err && s_wdata_i[1:0] != 2'h3) begin
            kind  <= ccd_pkg::ccd_kind_t'(s_wdata_i[1:0]);
            idx   <= 5'h00;
            word  <= (s_wdata_i[1:0] == ccd_pkg::KIND_RATE) ? `CCD_OP_RATE :
                     (s_wdata_i[1:0] == ccd_pkg::KIND_CONNECT) ?
                     `CCD_OP_CONNECT : `CCD_OP_LOCAL;
            len   <= (s_wdata_i[1:0] == ccd_pkg::KIND_RATE) ? `CCD_LEN_RATE :
                     (s_wdata_i[1:0] == ccd_pkg::KIND_CONNECT) ?
                     `CCD_LEN_CONNECT : `CCD_LEN_LOCAL;
            valid <= 1'b1;
            state <= ccd_pkg::HST_SEND;
          end
        end
        ccd_pkg::HST_SEND: begin
          if (link.err) begin
            valid <= 1'b0;
            state <= ccd_pkg::HST_WAIT;
          end else if (link.cmd_ready) begin
            if (idx == len - 5'h01) begin
              valid <= 1'b0;
              state <= ccd_pkg::HST_WAIT;
            end else begin
              idx  <= idx + 5'h01;
              word <= word_at(idx + 5'h01);
            end
          end
        end
        ccd_pkg::HST_WAIT: begin
          if (link.ack || link.err) begin
            state <= ccd_pkg::HST_IDLE;
          end
        end
        default: begin
          state <= ccd_pkg::HST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tb/ccd_link_asserts.sv
// concurrent checks on the command link
`include "ccd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccd_link_asserts (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // link
  input wire logic [15:0] cmd_word,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        ack,
  input wire logic        err,
  input wire logic        err_clr
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic        tk, lw, rt, ok;
  logic [4:0]  n_q, n_b;
  logic [15:0] op_q;
  assign tk = cmd_valid & cmd_ready;
  // ack cycle may open the next command
  assign n_b = (ack | err) ? 5'h00 : n_q;
  assign lw = tk & ((op_q == `CCD_OP_RATE && n_b == 5'h01) ||
    (op_q == `CCD_OP_LOCAL && n_b == 5'h05) ||
    (op_q == `CCD_OP_CONNECT && n_b == 5'h11));
  assign rt = lw & (op_q == `CCD_OP_RATE);
  assign ok = cmd_word <= `CCD_RATE_MAXCODE || cmd_word == `CCD_RATE_SWITCH;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) n_q <= 5'h00;
    else n_q <= tk ? n_b + 5'h01 : n_b;
    if (tk && n_b == 5'h00) op_q <= cmd_word;
  end
  //////////////////////////////////////////////////////////////////////////
  property p_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word not held");
  property p_ack; ack |=> !ack; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_excl; !(ack && err); endproperty
  a_excl: assert property (p_excl) else $error("ack with err");
  property p_halt; err && !err_clr |=> err; endproperty
  a_halt: assert property (p_halt) else $error("err lost");
  property p_shut; err |-> !cmd_ready; endproperty
  a_shut: assert property (p_shut) else $error("ready in halt");
  property p_busy; lw |=> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready too soon");
  property p_rate; rt && ok |-> ##3 ack; endproperty
  a_rate: assert property (p_rate) else $error("no rate ack");
  property p_bad; rt && !ok |-> ##[1:4] err; endproperty
  a_bad: assert property (p_bad) else $error("bad rate taken");
  c_rate: cover property (rt);
  c_conn: cover property (lw && op_q == `CCD_OP_CONNECT);
  c_err: cover property ($rose(err));
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// bench: host and device on one link, store modelled
`include "ccd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'b0, rst_b_i = 1'b0;
  logic        aw = 1'b0, w = 1'b0, b = 1'b0, ar = 1'b0, rr = 1'b0;
  logic        awr, wr, bv, arr, rv, irq, dreq, dwe, rwe;
  logic        dack = 1'b0, derr = 1'b0, dtod = 1'b0;
  logic [7:0]  aa = 8'h00, ra = 8'h00, dsub, w_sub;
  logic [1:0]  br, rsp, rs;
  logic [3:0]  sw = 4'h0, rate;
  logic [15:0] didx, radr, w_idx, la;
  logic [31:0] wd = 32'h0000_0000, rd, q, dwd, rwd, w_dat, ld, pd;
  logic [31:0] drd = 32'h0000_0000, drh = 32'h0000_0000;
  logic [23:0] rows [11] = '{24'h00_0000, 24'h00_0101, 24'h00_0202,
    24'h00_0303, 24'h00_0404, 24'h00_0505, 24'h00_0606, 24'h00_0707,
    24'h00_0808, 24'h00_ffc0, 24'h00_ff33};
  int          n_dw = 0, n_rw = 0, n0, k, n_mismatch = 0, num_checks = 0;
  ccd_link_if lnk ();
  ccd_host u_ccd_host (.clk_i, .rst_b_i, .s_awaddr_i(aa), .s_awvalid_i(aw),
    .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hf), .s_wvalid_i(w),
    .s_wready_o(wr), .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(b),
    .s_araddr_i(ra), .s_arvalid_i(ar), .s_arready_o(arr), .s_rdata_o(rd),
    .s_rresp_o(rsp), .s_rvalid_o(rv), .s_rready_i(rr), .irq_o(irq),
    .link(lnk));
  ccd_device u_ccd_device (.clk_i, .rst_b_i, .link(lnk), .rot_sw_i(sw),
    .can_rate_o(rate), .dict_req_o(dreq), .dict_we_o(dwe),
    .dict_index_o(didx), .dict_sub_o(dsub), .dict_wdata_o(dwd),
    .dict_wdata_hi_o(), .dict_ack_i(dack), .dict_err_i(derr),
    .dict_tod_i(dtod), .dict_rdata_i(drd), .dict_rdata_hi_i(drh),
    .reg_we_o(rwe), .reg_addr_o(radr), .reg_wdata_o(rwd),
    .reg_rdata_i({16'h5a00, radr}));
  ccd_link_asserts u_ccd_link_asserts (.clk_i, .rst_b_i,
    .cmd_word(lnk.cmd_word), .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready), .ack(lnk.ack), .err(lnk.err),
    .err_clr(lnk.err_clr));
  always #5 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////////
  // store acks one cycle after a request
  always @(posedge clk_i) begin
    dack <= dreq && !dack;
    if (dack && dreq && dwe) begin
      n_dw <= n_dw + 1;
      {w_idx, w_sub, w_dat} <= {didx, dsub, dwd};
    end
    if (rwe) begin
      n_rw <= n_rw + 1;
      {la, ld, pd} <= {radr, rwd, ld};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out(input bit t);
    n_mismatch += t;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, v);
    num_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, v);
    end
  endtask
  // one transfer; channels released when taken
  task automatic axi(input bit t, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    if (t) {aa, wd, aw, w, b} <= {a, d, 3'b111};
    else {ra, ar, rr} <= {a, 2'b11};
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (awr) aw <= 1'b0;
      if (wr) w <= 1'b0;
      if (arr) ar <= 1'b0;
      if (bv || rv) break;
    end
    {q, rs} = {rd, t ? br : rsp};
    {b, rr} <= 2'b00;
    if (i == 40) close_out(1'b1);
  endtask
  task automatic cmd(input ccd_pkg::ccd_kind_t t, input logic [31:0] a, b,
                     c, input bit wt);
    int i;
    axi(1'b1, `CCD_OFF_P0, a);
    axi(1'b1, `CCD_OFF_P1, b);
    axi(1'b1, `CCD_OFF_P2, c);
    axi(1'b1, `CCD_OFF_CMD, {30'h0000_0000, t});
    for (i = 0; i < 300 && wt; i++) begin
      @(posedge clk_i);
      if (lnk.ack === 1'b1 || lnk.err === 1'b1) break;
    end
    if (wt && i == 300) close_out(1'b1);
  endtask
  task automatic fault();
    chk("halted", 32'h1, 32'(lnk.err));
    axi(1'b1, `CCD_OFF_ERR_CLR, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk("resumed", 32'h0, 32'(lnk.err));
    axi(1'b1, `CCD_OFF_IRQ_STAT, 32'h0000_0003);
  endtask
  task automatic cdict(input logic [15:0] i, input logic [7:0] s,
                       input logic [31:0] d);
    chk("obj idx", 32'(i), 32'(w_idx));
    chk("obj sub", 32'(s), 32'(w_sub));
    chk("obj data", d, w_dat);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    chk("rate rst", 32'h0, 32'(rate));
    axi(1'b0, `CCD_OFF_IRQ_MASK, 0);
    chk("mask reset", 32'h0, q);
    axi(1'b0, 8'h20, 0);
    chk("unmapped", 32'h2, {q[29:0], rs});
    axi(1'b1, 8'h20, 0);
    chk("unmapped wr", 32'h2, 32'(rs));
    for (k = 0; k < 11; k++) begin
      sw <= rows[k][7:4];
      cmd(ccd_pkg::KIND_RATE, 32'(rows[k][23:8]), 0, 0, 1'b1);
      repeat (2) @(posedge clk_i);
      chk("rate", 32'(rows[k][3:0]), 32'(rate));
    end
    axi(1'b1, `CCD_OFF_IRQ_MASK, 32'h0000_0002);
    cmd(ccd_pkg::KIND_RATE, 32'h0000_0009, 0, 0, 1'b1);
    repeat (2) @(posedge clk_i);
    chk("rate kept", 32'h3, 32'(rate));
    chk("irq set", 32'h1, 32'(irq));
    axi(1'b1, `CCD_OFF_IRQ_MASK, 0);
    repeat (2) @(posedge clk_i);
    chk("irq mask", 32'h0, 32'(irq));
    fault();
    axi(1'b1, `CCD_OFF_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("irq clr", 32'h0, 32'(irq));
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("rate reset", 32'h0, 32'(rate));
    rst_b_i <= 1'b1;
    cmd(ccd_pkg::KIND_LOCAL, 2, 32'h1234_5678, 32'h0001_1006, 1'b1);
    cdict(16'h1006, 8'h01, 32'h1234_5678);
    cmd(ccd_pkg::KIND_LOCAL, 1, 7, 32'h0002_2010, 1'b1);
    cdict(16'h2010, 8'h02, 32'h5a00_0007);
    sw <= 4'h9;
    cmd(ccd_pkg::KIND_LOCAL, 0, 12, 32'h0000_200a, 1'b1);
    chk("sw field", 32'h0000_0090, ld);
    chk("sw reg", 32'h0000_000c, 32'(la));
    {dtod, drd, drh} <= {1'b1, 32'h1111_2222, 32'h3333_4444};
    n0 = n_rw;
    cmd(ccd_pkg::KIND_LOCAL, 0, 30, 32'h0000_1234, 1'b1);
    chk("tod n", 32'h2, 32'(n_rw - n0));
    chk("tod low", 32'h1111_2222, pd);
    chk("tod high", 32'h3333_4444, ld);
    chk("tod reg", 32'h0000_001f, 32'(la));
    dtod <= 1'b0;
    cmd(ccd_pkg::KIND_LOCAL, 3, 0, 0, 1'b1);
    fault();
    derr <= 1'b1;
    cmd(ccd_pkg::KIND_LOCAL, 2, 1, 1, 1'b1);
    derr <= 1'b0;
    fault();
    n0 = n_dw;
    cmd(ccd_pkg::KIND_CONNECT, 5, 2, 0, 1'b1);
    chk("conn writes", 32'h3, 32'(n_dw - n0));
    cdict(16'h1281, 8'h03, 32'h0000_0005);
    n0 = n_dw;
    cmd(ccd_pkg::KIND_CONNECT, 0, 1, 0, 1'b0);
    repeat (30) @(posedge clk_i);
    chk("refused", 32'h0, 32'(n_dw - n0));
    close_out(1'b0);
  end
endmodule
`default_nettype wire
